// >>> src/debug_wire_defines.vh
// Constants for the debug wire error handler
`ifndef DEBUG_WIRE_DEFINES_VH
`define DEBUG_WIRE_DEFINES_VH
`define BREAK_BITS        10
`define ANSWER_BREAK_CYC  4096
`define BIT_CNT_W         16
`define BRK_CNT_W         20
`define ANS_CNT_W         13
`define ST_IDLE           3'h0
`define ST_ANSWER         3'h1
`define ST_WAIT_HIGH      3'h2
`define ST_AUTOBAUD       3'h3
`define ST_READY          3'h4
`endif

// >>> src/low_run_counter.v
// Counts consecutive low samples of the debug wire
`timescale 1ns/1ps
`include "debug_wire_defines.vh"
module low_run_counter #(
  parameter W = 20
) (
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         ce,
  input  wire         line_low,
  input  wire [W-1:0] limit,
  output reg          reached
);
  reg [W-1:0] count;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      count   <= {W{1'b0}};
      reached <= 1'b0;
    end else if (ce) begin
      if (!line_low) begin
        count   <= {W{1'b0}};
        reached <= 1'b0;
      end else begin
        if (count != {W{1'b1}})
          count <= count + {{(W-1){1'b0}}, 1'b1};
        // Saturate so a long break stays recognised
        // Sticky, so a count wrap at saturation cannot drop a long break
        reached <= reached ||
                   ((limit != {W{1'b0}}) && (count + {{(W-1){1'b0}}, 1'b1} >= limit));
      end
    end
  end
endmodule

// >>> src/debug_wire_error_handler.v
// Error detection and recovery for the single-wire debug link
//
// Notes on behaviour
// - A low wire for ten or more bit periods is a break.
// - A stop bit sampled low is a framing error.
// - Host pulling the wire while we send a high bit is a collision.
// - Any error aborts the debug command in progress.
// - Any error is answered with a 4096-cycle break driven on the wire.
// - Any error resets the baud detector and generator.
// - A host break resets baud timing but keeps debug control contents.
// - Halted debug state survives a break.
// - Debug engine held in reset through the break until the wire is high.
// - Both parties only pull low or release the wire.
`timescale 1ns/1ps
`include "debug_wire_defines.vh"
module debug_wire_error_handler #(
  parameter ANSWER_CYC = `ANSWER_BREAK_CYC,
  parameter BREAK_BITS = `BREAK_BITS
) (
  input  wire                  clk_sys,
  input  wire                  sys_rst,
  input  wire                  ce,
  input  wire                  debug_wire_pin_in,
  output wire                  debug_wire_pin_out,
  output wire                  debug_wire_pin_oe_n,
  input  wire                  tx_active,
  input  wire                  tx_bit,
  input  wire                  rx_stop_valid,
  input  wire                  rx_stop_bit,
  input  wire                  baud_valid,
  input  wire [`BIT_CNT_W-1:0] baud_period,
  input  wire                  halted_in,
  output reg                   cmd_abort,
  output reg                   baud_reset,
  output reg                   engine_reset,
  output reg                   link_ready,
  output reg                   err_break,
  output reg                   err_framing,
  output reg                   err_collision,
  output reg                   halted_keep
);
  reg [2:0]              state;
  reg [2:0]              next_state;
  reg [`ANS_CNT_W-1:0]   ans_count;
  reg [`ANS_CNT_W-1:0]   next_ans_count;
  reg [`BIT_CNT_W-1:0]   bit_period;
  reg                    period_known;
  reg                    next_timing_reset;
  reg                    next_link_ready;
  wire                   brk_seen;
  wire                   line_low;
  wire                   live;
  wire [`BRK_CNT_W-1:0]  brk_limit;
  wire [`BRK_CNT_W-1:0]  period_wide;
  wire [`BRK_CNT_W-1:0]  bits_wide;
  wire                   break_err;
  wire                   framing;
  wire                   collision;
  wire                   any_err;
  wire                   ans_done;
  wire [`ANS_CNT_W-1:0]  ans_step;
  wire [`ANS_CNT_W-1:0]  ans_last;

  assign line_low = ~debug_wire_pin_in;
  assign live     = (state == `ST_READY);

  // Break length is counted in learned bit periods
  assign period_wide = {{(`BRK_CNT_W-`BIT_CNT_W){1'b0}}, bit_period};
  assign bits_wide   = BREAK_BITS[`BRK_CNT_W-1:0];

  // Without a learned period the break length is unknown; wait for timing first
  assign brk_limit = period_known ? (period_wide * bits_wide) : {`BRK_CNT_W{1'b0}};

  low_run_counter #(
    .W        (`BRK_CNT_W)
  ) u_low_run (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .line_low (line_low),
    .limit    (brk_limit),
    .reached  (brk_seen)
  );

  // Errors only count while the link is live; stray edges after a break are ignored
  assign break_err = live && brk_seen;
  assign framing   = live && rx_stop_valid && !rx_stop_bit;
  assign collision = live && tx_active && tx_bit && line_low;
  assign any_err   = break_err || framing || collision;

  // Answer length counter end point
  assign ans_step = {{(`ANS_CNT_W-1){1'b0}}, 1'b1};
  assign ans_last = ANSWER_CYC[`ANS_CNT_W-1:0] - ans_step;
  assign ans_done = (ans_count == ans_last);

  // Open drain: only ever drive low, otherwise release
  assign debug_wire_pin_out  = 1'b0;
  assign debug_wire_pin_oe_n = (state != `ST_ANSWER);

  always @* begin
    next_state = state;
    case (state)
      `ST_IDLE: begin
        next_state = `ST_WAIT_HIGH;
      end
      `ST_READY: begin
        if (any_err) begin
          next_state = `ST_ANSWER;
        end
      end
      `ST_ANSWER: begin
        if (ans_done) begin
          next_state = `ST_WAIT_HIGH;
        end
      end
      `ST_WAIT_HIGH: begin
        if (!line_low) begin
          next_state = `ST_AUTOBAUD;
        end
      end
      `ST_AUTOBAUD: begin
        // Wire activity here only feeds the baud detector
        if (baud_valid) begin
          next_state = `ST_READY;
        end
      end
      default: begin
        next_state = `ST_IDLE;
      end
    endcase
  end

  // Answer counter runs only while we pull the wire
  always @* begin
    next_ans_count = {`ANS_CNT_W{1'b0}};
    if (state == `ST_ANSWER) begin
      next_ans_count = ans_count + ans_step;
    end
  end

  // Timing and engine reset span the answer and the wait for a high wire
  always @* begin
    next_timing_reset = 1'b0;
    if (next_state == `ST_ANSWER) begin
      next_timing_reset = 1'b1;
    end
    if (next_state == `ST_WAIT_HIGH) begin
      next_timing_reset = 1'b1;
    end
  end

  always @* begin
    next_link_ready = 1'b0;
    if (next_state == `ST_READY) begin
      next_link_ready = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= `ST_IDLE;
      ans_count <= {`ANS_CNT_W{1'b0}};
    end else if (ce) begin
      state     <= next_state;
      ans_count <= next_ans_count;
    end
  end

  // Learned bit period; forgotten on every error so timing is relearned
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      bit_period   <= {`BIT_CNT_W{1'b0}};
      period_known <= 1'b0;
    end else if (ce) begin
      if (next_state == `ST_ANSWER) begin
        period_known <= 1'b0;
      end else if ((state == `ST_AUTOBAUD) && baud_valid) begin
        bit_period   <= baud_period;
        period_known <= 1'b1;
      end
    end
  end

  // One-cycle error reports and command abort
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_abort     <= 1'b0;
      err_break     <= 1'b0;
      err_framing   <= 1'b0;
      err_collision <= 1'b0;
    end else if (ce) begin
      cmd_abort     <= any_err;
      err_break     <= break_err;
      err_framing   <= framing;
      err_collision <= collision;
    end
  end

  // Reset pulses only the timing; control contents live elsewhere
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      baud_reset   <= 1'b1;
      engine_reset <= 1'b1;
      link_ready   <= 1'b0;
    end else if (ce) begin
      baud_reset   <= next_timing_reset;
      engine_reset <= next_timing_reset;
      link_ready   <= next_link_ready;
    end
  end

  // Halt is frozen while the engine sits in reset, so a break never clears it
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      halted_keep <= 1'b0;
    end else if (ce) begin
      if (!engine_reset) begin
        halted_keep <= halted_in;
      end
    end
  end
endmodule

// >>> verification/debug_wire_error_handler_props.sv
// Assertion checker for the debug wire error handler
`timescale 1ns/1ps
module debug_wire_error_handler_props #(parameter ANSWER_CYC = 16) (
  input logic clk_sys, sys_rst, ce, debug_wire_pin_in, debug_wire_pin_out,
  input logic debug_wire_pin_oe_n, rx_stop_valid, rx_stop_bit, baud_valid,
  input logic halted_in, cmd_abort, baud_reset, engine_reset, link_ready,
  input logic err_break, err_framing, err_collision, halted_keep
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] low_n;
  // Length of our own pull on the wire
  always @(posedge clk_sys)
    if (sys_rst || debug_wire_pin_oe_n) low_n <= 16'h0000;
    else if (ce) low_n <= low_n + 16'h0001;
  sequence s_err; err_break || err_framing || err_collision; endsequence
  sequence s_bad_stop; ce && link_ready && rx_stop_valid && !rx_stop_bit; endsequence
  property p_abort; s_err |-> cmd_abort; endproperty
  property p_reset; s_err |-> baud_reset && engine_reset; endproperty
  property p_answer; $rose(debug_wire_pin_oe_n) |-> low_n == ANSWER_CYC; endproperty
  property p_out; debug_wire_pin_out == 1'b0; endproperty
  property p_frame; s_bad_stop |=> err_framing; endproperty
  property p_eng; engine_reset && !debug_wire_pin_in |=> engine_reset; endproperty
  property p_halt; $past(engine_reset) |-> halted_keep == $past(halted_keep); endproperty
  property p_ready; $rose(link_ready) |-> $past(baud_valid) && !baud_reset; endproperty
  a_abort: assert property (p_abort) else $error("no abort on error");
  a_reset: assert property (p_reset) else $error("no baud reset");
  a_answer: assert property (p_answer) else $error("answer length wrong");
  a_out: assert property (p_out) else $error("wire driven high");
  a_frame: assert property (p_frame) else $error("framing missed");
  a_eng: assert property (p_eng) else $error("engine left reset early");
  a_halt: assert property (p_halt) else $error("halt state lost");
  a_ready: assert property (p_ready) else $error("ready without baud");
endmodule
bind debug_wire_error_handler debug_wire_error_handler_props #(.ANSWER_CYC(ANSWER_CYC)) u_props (.*);

// >>> verification/debug_host_model.sv
// Host side model pulling the shared wire low
`timescale 1ns/1ps
module debug_host_model (
  input  wire       clk_sys,
  input  wire       start,
  input  wire [7:0] len,
  output reg        pull = 1'b0
);
  reg [7:0] left = 8'h00;
  // Pull or release only, at any time, even mid character
  always @(posedge clk_sys) begin
    if (start) left <= len; else if (left != 8'h00) left <= left - 8'h01;
    pull <= start || left > 8'h01;
  end
endmodule

// >>> verification/debug_wire_error_handler_tb_top.sv
// Self-checking bench for the debug wire error handler
`timescale 1ns/1ps
module debug_wire_error_handler_tb_top;
  reg clk_sys = 1'b0, sys_rst = 1'b1, ce = 1'b1, tx_active = 1'b0, tx_bit = 1'b1;
  reg rx_stop_valid = 1'b0, rx_stop_bit = 1'b1, baud_valid = 1'b0, halted_in = 1'b0;
  reg start = 1'b0;
  reg [15:0] baud_period = 16'h0004;
  reg [7:0] len = 8'h00;
  wire pull, debug_wire_pin_out, debug_wire_pin_oe_n, cmd_abort, baud_reset, engine_reset;
  wire link_ready, err_break, err_framing, err_collision, halted_keep;
  wire debug_wire_pin_in = !(pull || !debug_wire_pin_oe_n);
  integer mismatches = 0, compares = 0, n;
  always #2.5 clk_sys = !clk_sys;
  debug_host_model host (.*);
  debug_wire_error_handler #(.ANSWER_CYC(16)) uut (.*);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task catch_err(input [5:0] exp);
    begin
      n = 0;
      while (!(err_break || err_framing || err_collision) && n < 200) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      if (n >= 200) begin
        mismatches = mismatches + 1;
        finish_test;
      end
      chk({err_break, err_framing, err_collision, cmd_abort, baud_reset, engine_reset}, exp);
      n = 0;
      while (debug_wire_pin_oe_n === 1'b0 && n < 99) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      chk(n, 16);
    end
  endtask
  task recover;
    begin
      n = 0;
      while (engine_reset !== 1'b0 && n < 200) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      if (n >= 200) begin
        mismatches = mismatches + 1;
        finish_test;
      end
      chk({engine_reset, debug_wire_pin_in}, 2'b01);
      rx_stop_valid = 1'b1;
      rx_stop_bit = 1'b0;
      @(negedge clk_sys);
      rx_stop_valid = 1'b0;
      rx_stop_bit = 1'b1;
      // Errors before a fresh baud measurement must be ignored
      chk(err_framing, 0);
      baud_period = 16'h0002 + $urandom % 4;
      baud_valid = 1'b1;
      @(negedge clk_sys);
      baud_valid = 1'b0;
      @(negedge clk_sys);
      chk(link_ready, 1);
    end
  endtask
  task pull_for(input [7:0] l);
    begin
      len = l;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
    end
  endtask
  task finish_test;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    finish_test;
  end
  initial begin
    n = $urandom(32'h9DF6);
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    recover;
    rx_stop_valid = 1'b1;
    rx_stop_bit = 1'b0;
    @(negedge clk_sys);
    rx_stop_valid = 1'b0;
    rx_stop_bit = 1'b1;
    catch_err(6'h17);
    recover;
    $display("framing test done");
    tx_active = 1'b1;
    pull_for(8'h05);
    catch_err(6'h0F);
    tx_active = 1'b0;
    recover;
    $display("collision test done");
    halted_in = $urandom % 2;
    // Just short of ten bit periods, no break yet
    pull_for(baud_period * 10 - 3);
    repeat (baud_period * 10 + 4) @(negedge clk_sys);
    chk(link_ready, 1);
    pull_for(baud_period * 10 + 30);
    catch_err(6'h27);
    chk({engine_reset, halted_keep}, {1'b1, halted_in});
    recover;
    $display("break test done");
    finish_test;
  end
endmodule
